// ### rtl/dabrb_top.sv
// data address generator for bit-indirect, fixed and stack addressing,
// plus the general register bank selector
// assumes requests are synchronous to core_clk and one per cycle
//
// Notes on behaviour
// - peripheral bit-indirect reaches only FC0H to FFFH
// - window base gives upper six bits, operand low four bits, L bits 3:2 the low two
// - peripheral bit-indirect ignores memory bank settings
// - high-nibble mode: H, operand nibble, memory bank
// - stack accesses hit bank 0 at pointer
// - stack serves interrupts, calls and push/pop
// - four banks of eight registers at 00H-1FH
// - active bank is enable AND select
// - enable flag saved on call, restored on return
// - interrupt saves flag, loads vector flag value
// - set/clear write flag, select writes select
// - registers usable as nibbles or pairs
// - register A of active bank is accumulator
// - primed pairs use bank with bit 0 flipped
// - fixed-area bit direct ignores memory bank settings
`timescale 1ns/1ps
module dabrb_top
(
   input  wire logic                     core_clk,
   input  wire logic                     rst,
   input  wire dabrb_pkg::dabrb_req_t    req,
   input  wire dabrb_pkg::dabrb_ptr_t    ptr,
   input  wire dabrb_pkg::dabrb_bank_op_t bank_op,
   input  wire logic [2:0]               reg_sel,
   input  wire logic [1:0]               pair_sel,
   input  wire logic                     pair_primed,
   output logic                          addr_valid,
   output logic [11:0]                   data_addr,
   output logic [1:0]                    bit_num,
   output logic [7:0]                    stack_ptr,
   output logic [1:0]                    active_bank,
   output logic [3:0]                    bank_select_value,
   output logic                          bank_enable_flag,
   output logic [4:0]                    reg_addr,
   output logic [4:0]                    acc_addr,
   output logic [4:0]                    pair_addr
);

   // bank selector outputs
   logic       en_w;
   logic [3:0] sel_w;
   logic [1:0] bank_w;
   // address generation
   logic [11:0] pmem_a;
   logic [11:0] hmem_a;
   logic [11:0] fmem_a;
   logic [11:0] push_a;
   logic [11:0] pop_a;
   logic [3:0]  hmem_bank;
   logic [1:0]  pair_bank;
   logic [7:0]  sp_r;
   logic [7:0]  sp_nxt;
   logic [7:0]  sp_dec;
   logic [11:0] addr_nxt;
   logic        pmem_in_win;

   // select register, enable flag and the enable flag save stack
   dabrb_bank_sel u_bank
   (
      .core_clk    (core_clk),
      .rst         (rst),
      .op          (bank_op),
      .enable_flag  (en_w),
      .select_value (sel_w),
      .active_bank (bank_w)
   );

   // peripheral window: base is fixed, so out-of-window is impossible
   assign pmem_in_win = (req.operand[9:4] == dabrb_pkg::PMEM_BASE_HI[9:4]);
   assign pmem_a = {dabrb_pkg::PMEM_BASE_HI[9:4], req.operand[3:0],
                    ptr.l_reg[3:2]};
   // memory bank only when enabled, else bank 0
   assign hmem_bank = ptr.memory_bank_enable_flag
                      ? ptr.memory_bank_select_value
                      : dabrb_pkg::BANK0;
   assign hmem_a = {hmem_bank, ptr.h_reg, req.fop[3:0]};
   // fixed area: choose port or interrupt page by operand bit 4
   assign fmem_a = {req.fop[4] ? dabrb_pkg::FMEM_PORT_HI
                               : dabrb_pkg::FMEM_IRQ_HI,
                    req.fop[3:0]};
   assign sp_dec = sp_r - dabrb_pkg::SP_ONE;
   assign push_a = {dabrb_pkg::BANK0, sp_dec};
   assign pop_a  = {dabrb_pkg::BANK0, sp_r};

   // address mux; unknown modes give address 0 but still raise addr_valid
   always_comb
   begin
      addr_nxt = '0;
      sp_nxt   = sp_r;
      case (req.mode)
         dabrb_pkg::DABRB_M_PMEM: addr_nxt = pmem_a;
         dabrb_pkg::DABRB_M_HMEM: addr_nxt = hmem_a;
         dabrb_pkg::DABRB_M_FMEM: addr_nxt = fmem_a;
         dabrb_pkg::DABRB_M_PUSH:
         begin
            addr_nxt = push_a;
            if (req.valid)
               sp_nxt = sp_dec;
         end
         dabrb_pkg::DABRB_M_POP:
         begin
            addr_nxt = pop_a;
            if (req.valid)
               sp_nxt = sp_r + dabrb_pkg::SP_ONE;
         end
         default: addr_nxt = '0;
      endcase
   end

   // registered address outputs and stack pointer
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         addr_valid <= 1'b0;
         data_addr  <= '0;
         bit_num    <= '0;
         sp_r       <= dabrb_pkg::SP_RESET;
      end
      else
      begin
         addr_valid <= req.valid && (req.mode != dabrb_pkg::DABRB_M_NONE);
         data_addr  <= addr_nxt;
         bit_num    <= req.bitno;
         sp_r       <= sp_nxt;
      end
   end

   // primed pairs come from the neighbour bank
   assign pair_bank = pair_primed ? {bank_w[1], ~bank_w[0]} : bank_w;

   // register area outputs, all in bank 0 at 00H-1FH
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         reg_addr          <= '0;
         acc_addr          <= '0;
         pair_addr         <= '0;
         active_bank       <= '0;
         bank_select_value <= dabrb_pkg::SEL_RESET;
         bank_enable_flag  <= dabrb_pkg::EN_RESET;
         stack_ptr         <= dabrb_pkg::SP_RESET;
      end
      else
      begin
         reg_addr          <= {bank_w, reg_sel};
         acc_addr          <= {bank_w, dabrb_pkg::REG_ACC};
         pair_addr         <= {pair_bank, pair_sel, 1'b0};
         active_bank       <= bank_w;
         bank_select_value <= sel_w;
         bank_enable_flag  <= en_w;
         stack_ptr         <= sp_nxt;
      end
   end

   // checks; every output is registered, so each request or pair check looks one edge
   // after its trigger and each bank op check two edges after the strobe; AST_BANK and AST_ACC compare outputs in the same cycle
   AST_PMEM_WIN: assert property (
      @(posedge core_clk) disable iff (rst)
      req.valid && req.mode == dabrb_pkg::DABRB_M_PMEM |=>
         data_addr >= dabrb_pkg::PMEM_LO
         && data_addr <= dabrb_pkg::PMEM_HI)
      else $error("peripheral address outside window");
   // an operand that names the window must come through unchanged
   AST_PMEM_OP: assert property (
      @(posedge core_clk) disable iff (rst)
      req.valid && req.mode == dabrb_pkg::DABRB_M_PMEM && pmem_in_win |=>
         data_addr[11:2] == $past(req.operand))
      else $error("peripheral upper bits not from operand");
   AST_PMEM_L: assert property (
      @(posedge core_clk) disable iff (rst)
      req.valid && req.mode == dabrb_pkg::DABRB_M_PMEM |=>
         data_addr[1:0] == $past(ptr.l_reg[3:2]))
      else $error("peripheral low bits not from pointer");
   AST_HMEM: assert property (
      @(posedge core_clk) disable iff (rst)
      req.valid && req.mode == dabrb_pkg::DABRB_M_HMEM
         && !ptr.memory_bank_enable_flag |=>
         data_addr[11:8] == dabrb_pkg::BANK0)
      else $error("high nibble mode bank wrong");
   // with the memory bank enabled the whole address is checked
   AST_HMEM_LOW: assert property (
      @(posedge core_clk) disable iff (rst)
      req.valid && req.mode == dabrb_pkg::DABRB_M_HMEM
         && ptr.memory_bank_enable_flag |=>
         data_addr == {$past(ptr.memory_bank_select_value),
                       $past(ptr.h_reg), $past(req.fop[3:0])})
      else $error("high nibble mode address wrong");
   AST_FMEM: assert property (
      @(posedge core_clk) disable iff (rst)
      req.valid && req.mode == dabrb_pkg::DABRB_M_FMEM |=>
         data_addr[11:4] == dabrb_pkg::FMEM_PORT_HI
         || data_addr[11:4] == dabrb_pkg::FMEM_IRQ_HI)
      else $error("fixed area address outside both windows");
   AST_PUSH: assert property (
      @(posedge core_clk) disable iff (rst)
      req.valid && req.mode == dabrb_pkg::DABRB_M_PUSH |=>
         stack_ptr == $past(sp_r) - dabrb_pkg::SP_ONE
         && data_addr == {dabrb_pkg::BANK0, stack_ptr})
      else $error("push address or pointer wrong");
   AST_STACK_B0: assert property (
      @(posedge core_clk) disable iff (rst)
      req.valid && req.mode == dabrb_pkg::DABRB_M_POP |=>
         data_addr[11:8] == dabrb_pkg::BANK0)
      else $error("stack left bank 0");
   // pop reads at the old pointer and only then steps it up
   AST_POP: assert property (
      @(posedge core_clk) disable iff (rst)
      req.valid && req.mode == dabrb_pkg::DABRB_M_POP |=>
         stack_ptr == $past(sp_r) + dabrb_pkg::SP_ONE
         && data_addr == {dabrb_pkg::BANK0, $past(sp_r)})
      else $error("pop address or pointer wrong");
   AST_BANK: assert property (
      @(posedge core_clk) disable iff (rst)
      !bank_enable_flag |-> active_bank == 2'h0)
      else $error("bank not forced to 0");
   AST_ACC: assert property (
      @(posedge core_clk) disable iff (rst)
      acc_addr == {active_bank, dabrb_pkg::REG_ACC})
      else $error("accumulator not in active bank");
   // primed bank differs from the active one in bit 0 only
   AST_PAIR: assert property (
      @(posedge core_clk) disable iff (rst)
      pair_primed |=> pair_addr[4:3] != active_bank
         && pair_addr[4] == active_bank[1])
      else $error("primed pair not in neighbour bank");
   AST_VEC: assert property (
      @(posedge core_clk) disable iff (rst)
      bank_op.int_entry |=> ##1
         bank_enable_flag == $past(bank_op.vec_en, 2))
      else $error("vector flag not loaded");
   AST_SEL: assert property (
      @(posedge core_clk) disable iff (rst)
      bank_op.sel_wr |=> ##1 bank_select_value
         == {dabrb_pkg::ZERO2, $past(bank_op.sel_val[1:0], 2)})
      else $error("select value not loaded");

endmodule : dabrb_top

// ### include/dabrb_pkg.sv
// package for the data address generator and register bank selector
// assumes a 12-bit data address space and 4-bit data nibbles
package dabrb_pkg;

   localparam int DAW = 12;                   // data address width
   localparam int SPW = 8;                    // stack pointer width
   // peripheral bit-indirect window base (FC0H), upper ten bits
   localparam logic [9:0]  PMEM_BASE_HI  = 10'h3F0;
   localparam logic [11:0] PMEM_LO       = 12'hFC0;
   localparam logic [11:0] PMEM_HI       = 12'hFFF;
   // fixed-area bit direct windows
   localparam logic [7:0]  FMEM_PORT_HI  = 8'hFF;   // FF0H..FFFH
   localparam logic [7:0]  FMEM_IRQ_HI   = 8'hFB;   // FB0H..FBFH
   // general register area in bank 0
   localparam logic [3:0]  BANK0         = 4'h0;
   localparam logic [1:0]  ZERO2         = 2'h0;
   localparam logic [3:0]  SEL_RESET     = 4'h0;    // bank select value
   localparam logic        EN_RESET      = 1'b0;    // bank enable flag
   localparam logic [7:0]  SP_RESET      = 8'h00;
   localparam logic [7:0]  SP_ONE        = 8'h01;
   localparam logic [2:0]  REG_ACC       = 3'h0;    // A at even offset, X above
   localparam int          SAVE_DEPTH    = 16;      // saved flag nesting
   localparam int          SAVE_PW       = 4;

   // address generation modes
   typedef enum logic [2:0]
   {
      DABRB_M_NONE  = 3'b000,
      DABRB_M_PMEM  = 3'b001,  // peripheral bit-indirect
      DABRB_M_HMEM  = 3'b010,  // high-nibble bit-indirect
      DABRB_M_FMEM  = 3'b011,  // fixed-area bit direct
      DABRB_M_PUSH  = 3'b100,  // stack push
      DABRB_M_POP   = 3'b101   // stack pop
   } dabrb_mode_t;

   // stack users
   typedef enum logic [1:0]
   {
      DABRB_S_DATA  = 2'b00,   // explicit push or pop
      DABRB_S_CALL  = 2'b01,   // subroutine call or return
      DABRB_S_INT   = 2'b10    // interrupt entry or return
   } dabrb_src_t;

   // request from the instruction sequencer
   typedef struct packed
   {
      logic        valid;
      dabrb_mode_t mode;
      dabrb_src_t  src;
      logic [9:0]  operand;   // pmem: low four bits give address bits 5:2, upper six ignored
      logic [7:0]  fop;       // hmem/fmem: low nibble / fixed address low
      logic [1:0]  bitno;     // bit number within the nibble
   } dabrb_req_t;

   // pointer and memory bank state supplied by the core
   typedef struct packed
   {
      logic [3:0] h_reg;
      logic [3:0] l_reg;
      logic       memory_bank_enable_flag;
      logic [3:0] memory_bank_select_value;
   } dabrb_ptr_t;

   // bank control operations
   typedef struct packed
   {
      logic       set_en;      // bit set instruction on the enable flag
      logic       clr_en;      // bit clear instruction on the enable flag
      logic       sel_wr;      // select instruction
      logic [3:0] sel_val;
      logic       int_entry;   // interrupt service starts
      logic       vec_en;      // enable flag from the vector entry
      logic       call;        // subroutine call
      logic       ret;         // subroutine or interrupt return
   } dabrb_bank_op_t;

endpackage : dabrb_pkg

// ### rtl/dabrb_bank_sel.sv
// register bank selector: enable flag, select register, flag save stack
// assumes bank ops arrive as single-cycle strobes from the sequencer
`timescale 1ns/1ps
module dabrb_bank_sel
(
   input  wire logic                     core_clk,
   input  wire logic                     rst,
   input  wire dabrb_pkg::dabrb_bank_op_t op,
   output logic                          enable_flag,
   output logic [3:0]                    select_value,
   output logic [1:0]                    active_bank
);

   logic [3:0] sel_r;                       // bank select value
   logic       en_r;                        // bank enable flag
   logic [dabrb_pkg::SAVE_DEPTH-1:0] save_r; // saved flags, bit stack
   logic [dabrb_pkg::SAVE_PW-1:0]    depth_r; // nesting depth
   logic       push_w;
   logic       pop_w;
   logic       en_nxt;
   logic [dabrb_pkg::SAVE_PW-1:0] top_w;

   assign push_w  = op.call | op.int_entry;
   assign pop_w   = op.ret & ~push_w;
   assign top_w   = depth_r - dabrb_pkg::SAVE_PW'(1);
   // interrupt entry loads the vector flag; return restores the saved one
   assign en_nxt  = op.int_entry ? op.vec_en :
                    pop_w        ? save_r[top_w] :
                    op.set_en    ? 1'b1 :
                    op.clr_en    ? 1'b0 : en_r;

   // flag and select register
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         en_r  <= dabrb_pkg::EN_RESET;
         sel_r <= dabrb_pkg::SEL_RESET;
      end
      else
      begin
         en_r <= en_nxt;
         // upper select bits are held at zero
         if (op.sel_wr)
            sel_r <= {dabrb_pkg::ZERO2, op.sel_val[1:0]};
      end
   end

   // save stack; a depth overflow wraps, as a hardware stack would
   always_ff @(posedge core_clk)
   begin
      if (rst)
         depth_r <= '0;
      else if (push_w)
      begin
         save_r[depth_r] <= en_r;
         depth_r         <= depth_r + dabrb_pkg::SAVE_PW'(1);
      end
      else if (pop_w)
         depth_r <= top_w;
   end

   assign enable_flag  = en_r;
   assign select_value = sel_r;
   assign active_bank  = sel_r[1:0] & {2{en_r}};

endmodule : dabrb_bank_sel

// ### sim/tb.sv
// self-checking bench for the data address and register bank block
// assumes dabrb_pkg is compiled first; inputs change on falling edges
`timescale 1ns/1ps
module tb;
   logic                      core_clk;     // 200 MHz core clock
   logic                      rst;          // sync reset, active high
   dabrb_pkg::dabrb_req_t     req;          // sequencer request
   dabrb_pkg::dabrb_ptr_t     ptr;          // pointer and memory bank
   dabrb_pkg::dabrb_bank_op_t bank_op;      // bank control strobes
   logic [2:0]                reg_sel;      // register index
   logic [1:0]                pair_sel;     // pair index
   logic                      pair_primed;  // use the primed bank
   logic                      addr_valid;
   logic [11:0]               data_addr;
   logic [1:0]                bit_num;
   logic [7:0]                stack_ptr;
   logic [1:0]                active_bank;
   logic [3:0]                bank_select_value;
   logic                      bank_enable_flag;
   logic [4:0]                reg_addr;
   logic [4:0]                acc_addr;
   logic [4:0]                pair_addr;
   int                        fail_count;       // mismatches seen
   int                        samples_checked;  // comparisons made

   dabrb_top i_dabrb_top
   (
      .core_clk (core_clk), .rst (rst), .req (req), .ptr (ptr),
      .bank_op (bank_op), .reg_sel (reg_sel), .pair_sel (pair_sel),
      .pair_primed (pair_primed), .addr_valid (addr_valid),
      .data_addr (data_addr), .bit_num (bit_num), .stack_ptr (stack_ptr),
      .active_bank (active_bank), .bank_select_value (bank_select_value),
      .bank_enable_flag (bank_enable_flag), .reg_addr (reg_addr),
      .acc_addr (acc_addr), .pair_addr (pair_addr)
   );

   // free-running core clock, 5 ns period
   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   // one comparison; four-state inequality so unknowns never match
   task automatic chk(input string name, input logic [11:0] seen,
                      input logic [11:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // the only exit of the run
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", samples_checked,
               fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict

   // request held one cycle; valid stays up so requests can run back to back
   task automatic rq(input dabrb_pkg::dabrb_mode_t m, input logic [9:0] op,
                     input logic [7:0] f, input logic [1:0] b,
                     input dabrb_pkg::dabrb_src_t s = dabrb_pkg::DABRB_S_DATA);
      req = '{1'b1, m, s, op, f, b};
      @(negedge core_clk);
   endtask : rq

   // one-cycle bank strobe, then wait out the two-cycle output delay
   task automatic bop(input dabrb_pkg::dabrb_bank_op_t o);
      bank_op = o;
      @(negedge core_clk);
      bank_op = '0;
      repeat (2) @(negedge core_clk);
   endtask : bop

   // peripheral window: every L register value, bank settings set to junk
   task automatic t_pmem;
      ptr = '{4'h9, 4'h0, 1'b1, 4'h5};
      for (int n = 0; n < 16; n++)
      begin
         ptr.l_reg = n[3:0];
         rq(dabrb_pkg::DABRB_M_PMEM, {6'h3F, n[3:0] ^ 4'h5}, 8'h00, 2'h0);
         chk("pmem_addr", data_addr, {6'h3F, n[3:0] ^ 4'h5, n[3:2]});
      end
      $display("test pmem done");
   endtask : t_pmem

   // high-nibble and fixed-area modes, then an idle mode
   task automatic t_bitmodes;
      for (int e = 0; e < 2; e++)
      begin
         ptr = '{4'hC, 4'h0, e[0], 4'h7};
         rq(dabrb_pkg::DABRB_M_HMEM, 10'h000, 8'h3A, 2'h2);
         chk("hmem_addr", data_addr, {e[0] ? 4'h7 : 4'h0, 8'hCA});
         chk("bit_num", bit_num, 12'h2);
      end
      rq(dabrb_pkg::DABRB_M_FMEM, 10'h000, 8'h1A, 2'h1);
      chk("fmem_port", data_addr, 12'hFFA);
      rq(dabrb_pkg::DABRB_M_FMEM, 10'h000, 8'h05, 2'h1);
      chk("fmem_irq", data_addr, 12'hFB5);
      chk("fmem_valid", addr_valid, 12'h1);
      rq(dabrb_pkg::DABRB_M_NONE, 10'h000, 8'h00, 2'h0);
      chk("none_valid", addr_valid, 12'h0);
      $display("test bit modes done");
   endtask : t_bitmodes

   // back-to-back pushes and pops across the pointer wrap, bank 0 forced
   task automatic t_stack;
      dabrb_pkg::dabrb_mode_t md [4];
      logic [7:0]             ea [4];
      logic [7:0]             sp [4];
      md = '{dabrb_pkg::DABRB_M_PUSH, dabrb_pkg::DABRB_M_PUSH,
             dabrb_pkg::DABRB_M_POP, dabrb_pkg::DABRB_M_POP};
      ea = '{8'hFF, 8'hFE, 8'hFE, 8'hFF};
      sp = '{8'hFF, 8'hFE, 8'hFF, 8'h00};
      ptr = '{4'h0, 4'h0, 1'b1, 4'h9};
      for (int i = 0; i < 4; i++)
      begin
         rq(md[i], 10'h000, 8'h00, 2'h0, dabrb_pkg::dabrb_src_t'(i % 3));
         chk("stack_addr", data_addr, {4'h0, ea[i]});
         chk("stack_ptr", stack_ptr, {4'h0, sp[i]});
      end
      req.valid = 1'b0;
      $display("test stack done");
   endtask : t_stack

   // select, enable, register, accumulator and primed pair addresses
   task automatic t_bank;
      bop('{sel_wr: 1'b1, sel_val: 4'hE, default: '0});
      chk("select", bank_select_value, 12'h2);
      chk("bank_off", active_bank, 12'h0);
      reg_sel = 3'h5;
      pair_sel = 2'h3;
      pair_primed = 1'b1;
      bop('{set_en: 1'b1, default: '0});
      chk("bank_on", active_bank, 12'h2);
      chk("reg_addr", reg_addr, 12'h15);
      chk("acc_addr", acc_addr, 12'h10);
      chk("pair_addr", pair_addr, 12'h1E);
      for (int n = 0; n < 4; n++)
      begin
         bop('{sel_wr: 1'b1, sel_val: n[3:0], default: '0});
         chk("bank_sel", active_bank, n[11:0]);
         chk("acc_sel", acc_addr, {7'h00, n[1:0], 3'h0});
         chk("pair_prime", pair_addr, {7'h00, n[1], ~n[0], 3'h6});
      end
      pair_primed = 1'b0;
      bop('{clr_en: 1'b1, default: '0});
      chk("bank_clr", active_bank, 12'h0);
      chk("pair_plain", pair_addr, 12'h06);
      $display("test bank done");
   endtask : t_bank

   // flag saved over a call and over interrupts with either vector value
   task automatic t_save;
      bop('{set_en: 1'b1, default: '0});
      bop('{call: 1'b1, default: '0});
      bop('{clr_en: 1'b1, default: '0});
      chk("flag_in_sub", bank_enable_flag, 12'h0);
      bop('{ret: 1'b1, default: '0});
      chk("flag_after_ret", bank_enable_flag, 12'h1);
      for (int v = 0; v < 2; v++)
      begin
         bop('{set_en: !v[0], clr_en: v[0], default: '0});
         bop('{int_entry: 1'b1, vec_en: v[0], default: '0});
         chk("flag_vector", bank_enable_flag, v[11:0]);
         bop('{sel_wr: 1'b1, sel_val: 4'h1, default: '0});
         bop('{ret: 1'b1, default: '0});
         chk("flag_int_ret", bank_enable_flag, {11'h0, !v[0]});
         chk("select_kept", bank_select_value, 12'h1);
      end
      $display("test save done");
   endtask : t_save

   // main sequence: 16-cycle reset, then each scenario in turn
   initial
   begin
      fail_count = 0;
      samples_checked = 0;
      rst = 1'b1;
      req = '0;
      ptr = '0;
      bank_op = '0;
      reg_sel = 3'h0;
      pair_sel = 2'h0;
      pair_primed = 1'b0;
      repeat (16) @(negedge core_clk);
      rst = 1'b0;
      chk("rst_valid", addr_valid, 12'h0);
      chk("rst_sp", stack_ptr, 12'h0);
      chk("rst_flag", bank_enable_flag, 12'h0);
      $display("test reset done");
      t_pmem;
      t_bitmodes;
      t_stack;
      t_bank;
      t_save;
      print_verdict;
   end

   // watchdog: the scenarios need a few hundred cycles at most
   initial
   begin
      repeat (4000) @(posedge core_clk);
      fail_count++;
      print_verdict;
   end
endmodule : tb
